// >>> src/gsci_top.sv
// Pin status, output data and change-interrupt logic of a 32-line parallel I/O controller.
// Assumes ownership and direction come from controller logic on clk_i; pins are asynchronous.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ns
`include "gsci_regs.svh"

module gsci_top (
  input  wire logic                 clk_i,
  input  wire logic                 reset_i,
  input  wire logic                 ce_i,
  // AXI4-Lite slave
  input  wire logic                 awvalid_i,
  output logic                      awready_o,
  input  wire gsci_pkg::gsci_addr_t awaddr_i,
  input  wire logic                 wvalid_i,
  output logic                      wready_o,
  input  wire gsci_pkg::gsci_word_t wdata_i,
  input  wire gsci_pkg::gsci_strb_t wstrb_i,
  output logic                      bvalid_o,
  input  wire logic                 bready_i,
  output gsci_pkg::gsci_resp_t      bresp_o,
  input  wire logic                 arvalid_i,
  output logic                      arready_o,
  input  wire gsci_pkg::gsci_addr_t araddr_i,
  output logic                      rvalid_o,
  input  wire logic                 rready_i,
  output gsci_pkg::gsci_word_t      rdata_o,
  output gsci_pkg::gsci_resp_t      rresp_o,
  // Controller configuration, same clock
  input  wire gsci_pkg::gsci_word_t owned_i,
  input  wire gsci_pkg::gsci_word_t out_en_i,
  // Pins
  input  wire gsci_pkg::gsci_word_t pin_i,
  output gsci_pkg::gsci_word_t      pin_out_o,
  output gsci_pkg::gsci_word_t      pin_oe_o,
  output logic                      irq_o
);
  import gsci_pkg::*;

  // ****************************************
  // State
  // ****************************************
  gsci_addr_t aw_addr;
  gsci_word_t w_data;
  gsci_strb_t w_strb;
  gsci_word_t wr_bits;
  gsci_word_t out_data;
  gsci_word_t irq_mask;
  gsci_word_t irq_status;
  gsci_word_t pin_s1;
  gsci_word_t pin_s2;
  gsci_word_t pin_prev;
  gsci_word_t edges;
  gsci_word_t stat_clr;
  gsci_word_t next_rdata;
  gsci_resp_t next_rresp;
  gsci_resp_t next_bresp;
  logic [1:0] sync_fill;
  logic       primed;
  logic       wr_go;
  logic       rd_go;

  // Write commits once address and data are both held
  assign wr_go = ce_i & ~awready_o & ~wready_o & ~bvalid_o;
  assign rd_go = ce_i & arvalid_i & arready_o;

  // Byte strobes gate the written bits per lane
  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign wr_bits[8*g +: 8] = w_data[8*g +: 8] & {8{w_strb[g]}};
  end

  // ****************************************
  // AXI4-Lite write channels
  // ****************************************
  // Address and data taken in either order, one write at a time
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      awready_o <= 1'b1;
      wready_o  <= 1'b1;
      aw_addr   <= '0;
      w_data    <= `GSCI_RST_WORD;
      w_strb    <= '0;
    end else if (ce_i) begin
      if (awvalid_i && awready_o) begin
        awready_o <= 1'b0;
        aw_addr   <= awaddr_i;
      end
      if (wvalid_i && wready_o) begin
        wready_o <= 1'b0;
        w_data   <= wdata_i;
        w_strb   <= wstrb_i;
      end
      if (wr_go) begin
        awready_o <= 1'b1;
        wready_o  <= 1'b1;
      end
    end
  end

  // Unmapped addresses answer SLVERR
  always_comb begin
    unique case (aw_addr[11:2])
      `GSCI_OFF_SET_OUT >> 2, `GSCI_OFF_CLR_OUT >> 2,
      `GSCI_OFF_OUT_STAT >> 2, `GSCI_OFF_PIN_STAT >> 2,
      `GSCI_OFF_IRQ_EN >> 2, `GSCI_OFF_IRQ_DIS >> 2,
      `GSCI_OFF_IRQ_MASK >> 2, `GSCI_OFF_IRQ_STAT >> 2: next_bresp = GSCI_RESP_OKAY;
      default:                                         next_bresp = GSCI_RESP_SLVERR;
    endcase
  end

  // Write response held until bready
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      bvalid_o <= 1'b0;
      bresp_o  <= GSCI_RESP_OKAY;
    end else if (ce_i) begin
      if (wr_go) begin
        bvalid_o <= 1'b1;
        bresp_o  <= next_bresp;
      end else if (bready_i) begin
        bvalid_o <= 1'b0;
      end
    end
  end

  // ****************************************
  // AXI4-Lite read channels
  // ****************************************
  // Read mux; write-only registers read as zero
  always_comb begin
    next_rdata = `GSCI_RST_WORD;
    next_rresp = GSCI_RESP_OKAY;
    unique case (araddr_i[11:2])
      `GSCI_OFF_OUT_STAT >> 2: next_rdata = out_data;
      `GSCI_OFF_PIN_STAT >> 2: next_rdata = pin_s2;
      `GSCI_OFF_IRQ_MASK >> 2: next_rdata = irq_mask;
      `GSCI_OFF_IRQ_STAT >> 2: next_rdata = irq_status;
      `GSCI_OFF_SET_OUT >> 2, `GSCI_OFF_CLR_OUT >> 2,
      `GSCI_OFF_IRQ_EN >> 2, `GSCI_OFF_IRQ_DIS >> 2: next_rdata = `GSCI_RST_WORD;
      default:                 next_rresp = GSCI_RESP_SLVERR;
    endcase
  end

  // Data captured at the address handshake, held until rready
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      arready_o <= 1'b1;
      rvalid_o  <= 1'b0;
      rdata_o   <= `GSCI_RST_WORD;
      rresp_o   <= GSCI_RESP_OKAY;
    end else if (ce_i) begin
      if (rd_go) begin
        arready_o <= 1'b0;
        rvalid_o  <= 1'b1;
        rdata_o   <= next_rdata;
        rresp_o   <= next_rresp;
      end else if (rvalid_o && rready_i) begin
        rvalid_o  <= 1'b0;
        arready_o <= 1'b1;
      end
    end
  end

  // ****************************************
  // Output data and pin drive
  // ****************************************
  // Set and clear writes; bits in neither are untouched
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      out_data <= `GSCI_RST_WORD;
    end else if (wr_go) begin
      if (aw_addr[11:2] == `GSCI_OFF_SET_OUT >> 2) begin
        out_data <= out_data | wr_bits;
      end else if (aw_addr[11:2] == `GSCI_OFF_CLR_OUT >> 2) begin
        out_data <= out_data & ~wr_bits;
      end
    end
  end

  // Value always presented; enable only when owned and output
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_out_o <= `GSCI_RST_WORD;
      pin_oe_o  <= `GSCI_RST_WORD;
    end else if (ce_i) begin
      pin_out_o <= out_data;
      pin_oe_o  <= owned_i & out_en_i;
    end
  end

  // ****************************************
  // Pin sampling and edge detection
  // ****************************************
  // Two-stage synchroniser, then one-clock history
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_s1    <= `GSCI_RST_WORD;
      pin_s2    <= `GSCI_RST_WORD;
      pin_prev  <= `GSCI_RST_WORD;
      sync_fill <= '0;
    end else if (ce_i) begin
      pin_s1   <= pin_i;
      pin_s2   <= pin_s1;
      pin_prev <= pin_s2;
      if (!primed) begin
        sync_fill <= sync_fill + 2'd1;
      end
    end
  end

  // Held off until history is real, so reset shows no false edges
  assign primed = (sync_fill == `GSCI_SYNC_FILL);
  assign edges  = primed ? (pin_s2 ^ pin_prev) : `GSCI_RST_WORD;

  // ****************************************
  // Interrupt mask, status and request
  // ****************************************
  // Enable sets and disable clears; other writes leave it alone
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_mask <= `GSCI_RST_WORD;
    end else if (wr_go) begin
      if (aw_addr[11:2] == `GSCI_OFF_IRQ_EN >> 2) begin
        irq_mask <= irq_mask | wr_bits;
      end else if (aw_addr[11:2] == `GSCI_OFF_IRQ_DIS >> 2) begin
        irq_mask <= irq_mask & ~wr_bits;
      end
    end
  end

  // Read clears all; writing ones also clears those bits
  always_comb begin
    stat_clr = `GSCI_RST_WORD;
    if (rd_go && araddr_i[11:2] == `GSCI_OFF_IRQ_STAT >> 2) begin
      stat_clr = `GSCI_ONES_WORD;
    end else if (wr_go && aw_addr[11:2] == `GSCI_OFF_IRQ_STAT >> 2) begin
      stat_clr = wr_bits;
    end
  end

  // New edge wins over a clear in the same cycle, so none is lost
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_status <= `GSCI_RST_WORD;
    end else if (ce_i) begin
      irq_status <= (irq_status & ~stat_clr) | edges;
    end
  end

  // Level request to the interrupt controller
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(irq_status & irq_mask);
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_out_stat_read: assert property (@(posedge clk_i) disable iff (reset_i)
    rd_go && araddr_i[11:2] == `GSCI_OFF_OUT_STAT >> 2 |=> rdata_o == $past(out_data))
    else $error("output status read mismatch");

  a_pin_drive: assert property (@(posedge clk_i) disable iff (reset_i)
    ce_i |=> pin_oe_o == $past(owned_i & out_en_i) && pin_out_o == $past(out_data))
    else $error("pin drive not gated by owner and direction");

  a_pin_level: assert property (@(posedge clk_i) disable iff (reset_i)
    ce_i ##1 ce_i ##1 (rd_go && araddr_i[11:2] == `GSCI_OFF_PIN_STAT >> 2)
    |=> rdata_o == $past(pin_i, 3))
    else $error("pin status does not follow pin");

  a_enable_mask: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_go && aw_addr[11:2] == `GSCI_OFF_IRQ_EN >> 2
    |=> (irq_mask & $past(wr_bits)) == $past(wr_bits) && (irq_mask | $past(irq_mask)) == irq_mask)
    else $error("enable write did not set mask");

  a_disable_mask: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_go && aw_addr[11:2] == `GSCI_OFF_IRQ_DIS >> 2
    |=> (irq_mask & $past(wr_bits)) == '0 && (irq_mask & $past(irq_mask)) == irq_mask)
    else $error("disable write did not clear mask");

  a_mask_stable: assert property (@(posedge clk_i) disable iff (reset_i)
    !(wr_go && aw_addr[11:3] == `GSCI_OFF_IRQ_EN >> 3) |=> $stable(irq_mask))
    else $error("mask changed without enable or disable write");

  a_edge_sets: assert property (@(posedge clk_i) disable iff (reset_i)
    ce_i && primed && pin_s2 != pin_prev |=> (irq_status & $past(pin_s2 ^ pin_prev)) != '0)
    else $error("edge not recorded in status");

  a_read_clears: assert property (@(posedge clk_i) disable iff (reset_i)
    rd_go && araddr_i[11:2] == `GSCI_OFF_IRQ_STAT >> 2 && edges == '0
    |=> irq_status == '0 && rdata_o == $past(irq_status))
    else $error("status not cleared by read");

  a_set_output: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_go && aw_addr[11:2] == `GSCI_OFF_SET_OUT >> 2
    |=> out_data == ($past(out_data) | $past(wr_bits)))
    else $error("set write wrong");

  a_clear_output: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_go && aw_addr[11:2] == `GSCI_OFF_CLR_OUT >> 2
    |=> out_data == ($past(out_data) & ~$past(wr_bits)))
    else $error("clear write wrong");

  a_irq_level: assert property (@(posedge clk_i) disable iff (reset_i)
    ce_i |=> irq_o == |($past(irq_status) & $past(irq_mask)))
    else $error("interrupt level wrong");

  a_edge_prompt: assert property (@(posedge clk_i) disable iff (reset_i)
    ce_i && primed && $changed(pin_s2) |-> edges == (pin_s2 ^ $past(pin_s2)))
    else $error("edge not seen against previous level");

  c_write_resp: cover property (@(posedge clk_i) disable iff (reset_i) bvalid_o && bready_i);
  c_irq_raise:  cover property (@(posedge clk_i) disable iff (reset_i) $rose(irq_o));
  c_read_clear: cover property (@(posedge clk_i) disable iff (reset_i)
    rd_go && araddr_i[11:2] == `GSCI_OFF_IRQ_STAT >> 2 && irq_status != '0);

endmodule : gsci_top

// >>> shared/gsci_regs.svh
// Register map, reset values and fixed counts of the pin status and change-interrupt block.
// Assumes byte addresses on a 32-bit AXI4-Lite bus; only address bits 11:2 are decoded.
`ifndef GSCI_REGS_SVH
`define GSCI_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define GSCI_OFF_SET_OUT    12'h030
`define GSCI_OFF_CLR_OUT    12'h034
`define GSCI_OFF_OUT_STAT   12'h038
`define GSCI_OFF_PIN_STAT   12'h03C
`define GSCI_OFF_IRQ_EN     12'h040
`define GSCI_OFF_IRQ_DIS    12'h044
`define GSCI_OFF_IRQ_MASK   12'h048
`define GSCI_OFF_IRQ_STAT   12'h04C

// ****************************************
// Reset values and counts
// ****************************************
`define GSCI_RST_WORD       32'h0000_0000
`define GSCI_ONES_WORD      32'hFFFF_FFFF
`define GSCI_SYNC_FILL      2'h3

`endif

// >>> shared/gsci_pkg.sv
// Types shared by the pin status and change-interrupt block.
// Assumes 32 lines and 32-bit AXI4-Lite data.
package gsci_pkg;

  // ****************************************
  // Types
  // ****************************************
  typedef logic [31:0] gsci_word_t;
  typedef logic [11:0] gsci_addr_t;
  typedef logic [3:0]  gsci_strb_t;

  typedef enum logic [1:0] {
    GSCI_RESP_OKAY   = 2'b00,
    GSCI_RESP_SLVERR = 2'b10
  } gsci_resp_t;

endpackage : gsci_pkg

// >>> tb/gsci_pin_model.sv
// Pin pad model: resolves each line from the block's drive and an outside driver.
// Assumes the bench supplies the outside level of every line.
`timescale 1ns/1ns

module gsci_pin_model (
  input  wire gsci_pkg::gsci_word_t pin_out_i,
  input  wire gsci_pkg::gsci_word_t pin_oe_i,
  input  wire gsci_pkg::gsci_word_t ext_drive_i,
  output gsci_pkg::gsci_word_t      pin_level_o
);
  import gsci_pkg::*;
  // Block wins where it drives, outside level elsewhere
  assign pin_level_o = (pin_out_i & pin_oe_i) | (ext_drive_i & ~pin_oe_i);
endmodule : gsci_pin_model

// >>> tb/tb_gpio_status_and_change_irq.sv
// Self-checking bench of the pin status and change-interrupt block.
// Assumes the pin model in its own file; bus ready inputs held high throughout.
`timescale 1ns/1ns
`include "gsci_regs.svh"

module tb_gpio_status_and_change_irq;
  import gsci_pkg::*;
  logic       clk_i = 1'b0, reset_i = 1'b1, ce_i = 1'b1, bready_i = 1'b1, rready_i = 1'b1;
  logic       awvalid_i = 1'b0, wvalid_i = 1'b0, arvalid_i = 1'b0;
  gsci_addr_t awaddr_i = '0, araddr_i = '0;
  gsci_word_t wdata_i = '0, owned_i = '0, out_en_i = '0, ext_drive = '0;
  gsci_strb_t wstrb_i = 4'hF;
  logic       awready_o, wready_o, bvalid_o, arready_o, rvalid_o, irq_o;
  gsci_resp_t bresp_o, rresp_o;
  gsci_word_t rdata_o, pin_i, pin_out_o, pin_oe_o, out_exp, mask_exp, rd, w, oe;
  gsci_resp_t rs;
  int         num_errors = 0, samples_checked = 0;

  // 10 MHz clock
  always #50 clk_i = ~clk_i;

  gsci_top DUT (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .awvalid_i(awvalid_i), .awready_o(awready_o),
    .awaddr_i(awaddr_i), .wvalid_i(wvalid_i), .wready_o(wready_o), .wdata_i(wdata_i), .wstrb_i(wstrb_i),
    .bvalid_o(bvalid_o), .bready_i(bready_i), .bresp_o(bresp_o), .arvalid_i(arvalid_i), .arready_o(arready_o),
    .araddr_i(araddr_i), .rvalid_o(rvalid_o), .rready_i(rready_i), .rdata_o(rdata_o), .rresp_o(rresp_o),
    .owned_i(owned_i), .out_en_i(out_en_i), .pin_i(pin_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
    .irq_o(irq_o));

  gsci_pin_model PINS (.pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o), .ext_drive_i(ext_drive), .pin_level_o(pin_i));

  // ****************************************
  // Bench tasks
  // ****************************************
  task automatic chk(input gsci_word_t seen, input gsci_word_t exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  // Write: both channels offered together, each dropped at its own take edge
  task automatic wr(input gsci_addr_t a, input gsci_word_t d, output gsci_resp_t r);
    logic pa, pw, ta, tw, b;
    pa = 1'b1;
    pw = 1'b1;
    b = 1'b0;
    awaddr_i <= a;
    wdata_i <= d;
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    while (pa || pw || !b) begin
      @(negedge clk_i);
      ta = pa && awready_o;
      tw = pw && wready_o;
      b = bvalid_o;
      r = bresp_o;
      @(posedge clk_i);
      if (ta) begin
        pa = 1'b0;
        awvalid_i <= 1'b0;
      end
      if (tw) begin
        pw = 1'b0;
        wvalid_i <= 1'b0;
      end
    end
  endtask : wr

  // Read: address held until its take edge, data taken with rvalid
  task automatic rdreg(input gsci_addr_t a, output gsci_word_t d, output gsci_resp_t r);
    logic t, tt, v;
    t = 1'b0;
    v = 1'b0;
    araddr_i <= a;
    arvalid_i <= 1'b1;
    while (!v) begin
      @(negedge clk_i);
      tt = !t && arready_o;
      v = t && rvalid_o;
      d = rdata_o;
      r = rresp_o;
      @(posedge clk_i);
      if (tt) begin
        t = 1'b1;
        arvalid_i <= 1'b0;
      end
    end
  endtask : rdreg

  // Level the pad settles to: block where enabled, outside driver elsewhere
  function automatic gsci_word_t pin_exp(input gsci_word_t out_v, input gsci_word_t oe_v, input gsci_word_t ext_v);
    return (out_v & oe_v) | (ext_v & ~oe_v);
  endfunction : pin_exp

  task automatic rchk(input gsci_addr_t a, input gsci_word_t e);
    rdreg(a, rd, rs);
    chk(rd, e, "read data");
    chk({30'h0, rs}, {30'h0, GSCI_RESP_OKAY}, "read response");
  endtask : rchk

  task automatic end_sim;
    if (num_errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim

  // Hang guard, far beyond the few hundred cycles of the run
  initial begin
    #2_000_000;
    num_errors++;
    end_sim();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    void'($urandom(32'h80fa_fc14));
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    rchk(`GSCI_OFF_IRQ_MASK, 32'h0000_0000);
    rchk(`GSCI_OFF_IRQ_STAT, 32'h0000_0000);
    rchk(`GSCI_OFF_OUT_STAT, 32'h0000_0000);
    // Unmapped place, both directions
    rdreg(12'h000, rd, rs);
    chk({30'h0, rs}, {30'h0, GSCI_RESP_SLVERR}, "unmapped read");
    wr(12'h000, 32'hFFFF_FFFF, rs);
    chk({30'h0, rs}, {30'h0, GSCI_RESP_SLVERR}, "unmapped write");
    // Random output programming, ownership, outside levels and mask updates
    out_exp = '0;
    mask_exp = '0;
    for (int i = 0; i < 12; i++) begin
      w = $urandom;
      owned_i <= $urandom;
      out_en_i <= $urandom;
      if (i % 2 == 0) begin
        wr(`GSCI_OFF_SET_OUT, w, rs);
        out_exp = out_exp | w;
      end else begin
        wr(`GSCI_OFF_CLR_OUT, w, rs);
        out_exp = out_exp & ~w;
      end
      rchk(`GSCI_OFF_OUT_STAT, out_exp);
      oe = owned_i & out_en_i;
      chk(pin_oe_o, oe, "pin enable");
      chk(pin_out_o & oe, out_exp & oe, "driven level");
      ext_drive <= $urandom;
      repeat (3) @(posedge clk_i);
      rchk(`GSCI_OFF_PIN_STAT, pin_exp(out_exp, oe, ext_drive));
      w = $urandom;
      wr(`GSCI_OFF_IRQ_EN, w, rs);
      mask_exp = mask_exp | w;
      w = $urandom;
      wr(`GSCI_OFF_IRQ_DIS, w, rs);
      mask_exp = mask_exp & ~w;
      rchk(`GSCI_OFF_IRQ_MASK, mask_exp);
    end
    // Quiet pins, all lines unmasked, stale status drained
    owned_i <= '0;
    wr(`GSCI_OFF_IRQ_EN, 32'hFFFF_FFFF, rs);
    repeat (5) @(posedge clk_i);
    rdreg(`GSCI_OFF_IRQ_STAT, rd, rs);
    rchk(`GSCI_OFF_IRQ_STAT, 32'h0000_0000);
    chk({31'h0, irq_o}, 32'h0000_0000, "irq idle");
    // Mixed rising and falling edges on peripheral-owned lines
    w = $urandom | 32'h0000_0001;
    ext_drive <= ext_drive ^ w;
    repeat (6) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0000_0001, "irq raised");
    wr(`GSCI_OFF_IRQ_DIS, 32'hFFFF_FFFF, rs);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0000_0000, "irq masked");
    rchk(`GSCI_OFF_IRQ_STAT, w);
    rchk(`GSCI_OFF_IRQ_STAT, 32'h0000_0000);
    // One-cycle pulse still leaves its mark while masked
    ext_drive <= ext_drive ^ 32'h0000_0002;
    @(posedge clk_i);
    ext_drive <= ext_drive ^ 32'h0000_0002;
    repeat (6) @(posedge clk_i);
    rchk(`GSCI_OFF_IRQ_STAT, 32'h0000_0002);
    // Pulse while the clock enable is low is never sampled
    ce_i <= 1'b0;
    ext_drive <= ext_drive ^ 32'h0000_0004;
    repeat (3) @(posedge clk_i);
    ext_drive <= ext_drive ^ 32'h0000_0004;
    repeat (3) @(posedge clk_i);
    ce_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rchk(`GSCI_OFF_IRQ_STAT, 32'h0000_0000);
    // Only the strobed byte lane takes the set write
    wstrb_i <= 4'h2;
    wr(`GSCI_OFF_SET_OUT, 32'hFFFF_FFFF, rs);
    wstrb_i <= 4'hF;
    out_exp = out_exp | 32'h0000_FF00;
    rchk(`GSCI_OFF_OUT_STAT, out_exp);
    // Mid-run reset drops a pending interrupt, status, mask and output data
    wr(`GSCI_OFF_IRQ_EN, 32'h0000_0008, rs);
    ext_drive <= ext_drive ^ 32'h0000_0008;
    repeat (6) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0000_0001, "irq before reset");
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    chk({31'h0, irq_o}, 32'h0000_0000, "irq in reset");
    @(posedge clk_i);
    rchk(`GSCI_OFF_IRQ_STAT, 32'h0000_0000);
    rchk(`GSCI_OFF_IRQ_MASK, 32'h0000_0000);
    rchk(`GSCI_OFF_OUT_STAT, 32'h0000_0000);
    end_sim();
  end
endmodule : tb_gpio_status_and_change_irq
